//--- hdl/timer16_capture_ppg.sv
// 16-bit timer with compare, soft capture and toggle output, Avalon-MM slave
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "timer16_params.svh"
module timer16_capture_ppg
    import timer16_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic external_count_input,
    input wire logic idle2_mode,
    output logic timer_output_pin,
    output logic overflow_irq,
    output logic match_a_irq,
    output logic match_b_irq
);

    // Overview of the datapath:
    //   clk -> divide-by-4 -> 5-bit prescaler -> fine, mid and coarse taps
    //   taps or synchronised pin edges -> 16-bit up-counter
    //   counter -> two comparators -> match pulses, buffered reload, toggle
    //   bus write of the capture strobe -> capture A latch -> toggle
    // All state sits in one packed struct, so reset and the next-state copy
    // cover every field; nothing else in the block holds a value.
    // The helpers below are plain decodes of that state, the bus inputs and idle2_mode.

    timer_state_type s;
    timer_state_type next_s;

    // Bus request qualifiers
    logic request;
    logic accept;
    logic act;
    logic wr_act;
    logic rd_act;
    logic lane0;
    logic lane1;
    logic [7:0] wbyte0;
    logic [7:0] wbyte1;

    // Prescaler and counting
    logic halted;
    logic presc_tick;
    logic tap_fine;
    logic tap_mid;
    logic tap_coarse;
    logic ext_edge;
    logic count_tick;
    logic clear_hit;
    logic [15:0] counter_next;
    logic ev_match_a;
    logic ev_match_b;
    logic ev_overflow;
    logic ev_capture;
    logic toggled;
    logic [31:0] read_value;

    // Bus timing, as seen from the master:
    //   edge 0: request sampled with waitrequest high, answer prepared
    //   edge 1: waitrequest low, the write lands, read data stand
    //   edge 2: waitrequest high again and the request has been dropped
    // One fixed wait state keeps the read path registered and short,
    // at the price of two clocks for every transfer.

    // Request is accepted one edge before it completes
    assign request = avs_read | avs_write;
    assign accept = request & s.waitrequest;
    assign act = request & ~s.waitrequest;
    assign wr_act = act & avs_write;
    assign rd_act = act & avs_read;
    assign lane0 = avs_byteenable[0];
    assign lane1 = avs_byteenable[1];
    assign wbyte0 = avs_writedata[7:0];
    assign wbyte1 = avs_writedata[15:8];

    // Tap periods with the prescaler running and no IDLE2 halt:
    //   fine every 8 clocks, mid every 32, coarse every 128
    // The taps are one-cycle enables, never clocks, so the counter and
    // everything behind it stay in the single clk domain.

    // IDLE2 freezes the prescaler unless software asked it to keep running
    assign halted = idle2_mode & ~s.idle2_run_enable;
    assign presc_tick = s.prescaler_run & ~halted & (s.div4 == 2'(`PRESC_IN_DIV - 1));
    assign tap_fine = presc_tick & s.prescaler[0];
    assign tap_mid = presc_tick & (&s.prescaler[2:0]);
    assign tap_coarse = presc_tick & (&s.prescaler);

    // Only the second synchroniser stage feeds the edge detector
    // The pin needs to stay high and low for only one clock each to be counted
    assign ext_edge = s.ext_sync2 & ~s.ext_prev & ~halted;

    // Source multiplexer
    always_comb begin
        case (s.clock_select)
            SRC_EXTERNAL: count_tick = ext_edge;
            SRC_FINE: count_tick = tap_fine;
            SRC_MID: count_tick = tap_mid;
            SRC_COARSE: count_tick = tap_coarse;
            default: count_tick = 1'b0;
        endcase
    end

    // Counter step: clear on compare B match, else wrap through full range.
    // With clear enabled the period is B + 1 ticks, since the tick after the
    // match returns the count to zero.
    assign clear_hit = s.match_clear_enable & (s.up_counter == s.compare_register_b);
    assign counter_next = clear_hit ? `RESET_WORD : s.up_counter + 16'h0001;

    // Events are seen when the counter arrives at a value, so a compare
    // value of zero fires only after a clear or the wrap from all ones; the overflow is the wrap from
    // all ones and is suppressed when a clear already takes the count to zero
    assign ev_match_a = s.run & count_tick & (counter_next == s.compare_register_a);
    assign ev_match_b = s.run & count_tick & (counter_next == s.compare_register_b);
    assign ev_overflow = s.run & count_tick & ~clear_hit & (s.up_counter == `COUNT_MAX);

    // Writing 0 to the soft-capture bit samples the counter
    // Limitation: the strobe is ignored while the prescaler is stopped, and
    // it latches the count that stands before the write edge
    assign ev_capture = wr_act & lane0 & (avs_address == `IDX_MOD)
        & ~avs_writedata[`MOD_SOFTCAP_BIT] & s.prescaler_run;

    // Each enabled source flips the output once; coincident flips cancel
    // Trade-off: cancelling needs no priority logic, but two events in one
    // cycle leave the output unchanged
    assign toggled = s.output_toggle_ff
        ^ (ev_match_a & s.match_a_toggle_enable)
        ^ (ev_match_b & s.match_b_toggle_enable)
        ^ (ev_capture & s.capture_toggle_enable);

    // Register map by word index:
    //   run control, mode, toggle control, compare A low and high,
    //   compare B low and high, capture A low and high, capture B low and high
    // A read of the capture A low index returns all 16 bits and freezes the
    // high byte, so a later byte read of the high index stays coherent even
    // when the counter has moved on in between.
    // Read multiplexer; write-only and unmapped locations return zero
    always_comb begin
        read_value = `RESET_READ;
        case (avs_address)
            `IDX_RUN: begin
                // Bits 1, 3, 4 and 5 are spare and read as zero
                read_value[`RUN_COUNT_BIT] = s.run;
                read_value[`RUN_PRESC_BIT] = s.prescaler_run;
                read_value[`RUN_IDLE2_BIT] = s.idle2_run_enable;
                read_value[`RUN_DBUF_BIT] = s.double_buffer_enable;
            end
            `IDX_MOD: begin
                read_value[`MOD_CLK_LSB +: 2] = s.clock_select;
                read_value[`MOD_CLEAR_BIT] = s.match_clear_enable;
                read_value[`MOD_SOFTCAP_BIT] = 1'b1;
            end
            `IDX_FFCR: begin
                // The command field is a strobe and reads back as no command
                read_value[`FFCR_CMD_LSB +: 2] = FF_KEEP;
                read_value[`FFCR_TA_BIT] = s.match_a_toggle_enable;
                read_value[`FFCR_TB_BIT] = s.match_b_toggle_enable;
                read_value[`FFCR_TC_BIT] = s.capture_toggle_enable;
            end
            `IDX_CAPA_LO: begin
                read_value[15:0] = s.capture_register_a;
            end
            `IDX_CAPA_HI: begin
                read_value[7:0] = s.read_hold;
            end
            `IDX_CMPA_LO, `IDX_CMPA_HI, `IDX_CMPB_LO, `IDX_CMPB_HI: begin
                // Compare registers are write-only and hide their contents
                read_value = `RESET_READ;
            end
            `IDX_CAPB_LO, `IDX_CAPB_HI: begin
                // No capture trigger input exists, so capture B never loads
                read_value = `RESET_READ;
            end
            default: begin
                read_value = `RESET_READ;
            end
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        next_s = s;

        // Bus handshake: one wait cycle, then completion
        if (accept) begin
            next_s.waitrequest = 1'b0;
        end else begin
            next_s.waitrequest = 1'b1;
        end

        // Read data move only for an accepted read and then hold
        if (accept && avs_read) begin
            next_s.readdata = read_value;
        end

        // Low byte of capture read freezes the high byte for the next read
        if (rd_act && avs_address == `IDX_CAPA_LO) begin
            next_s.read_hold = s.capture_register_a[15:8];
        end

        // Divide-by-4 front end of the prescaler
        // IDLE2 freezes the phase rather than clearing it, so the taps resume
        // with their spacing intact
        if (s.prescaler_run && !halted) begin
            next_s.div4 = s.div4 + 2'h1;
        end else if (!s.prescaler_run) begin
            next_s.div4 = 2'h0;
        end

        // Prescaler: counts while running, cleared when stopped
        if (!s.prescaler_run) begin
            next_s.prescaler = '0;
        end else if (presc_tick) begin
            next_s.prescaler = s.prescaler + `PRESC_WIDTH'(1);
        end

        // External input synchroniser and edge memory
        // The first stage may be metastable; nothing but the second reads it
        next_s.ext_sync1 = external_count_input;
        next_s.ext_sync2 = s.ext_sync1;
        next_s.ext_prev = s.ext_sync2;

        // Up-counter
        if (!s.run) begin
            next_s.up_counter = `RESET_WORD;
        end else if (count_tick) begin
            next_s.up_counter = counter_next;
        end

        // Buffered compare A reloads at compare B match
        if (ev_match_b && s.double_buffer_enable) begin
            next_s.compare_register_a = s.compare_buffer_a;
        end

        // Capture
        if (ev_capture) begin
            next_s.capture_register_a = s.up_counter;
        end

        // Interrupt pulses, one cycle each
        // Registered with the counter, so each pulse lines up with the new count
        next_s.overflow_irq = ev_overflow;
        next_s.match_a_irq = ev_match_a;
        next_s.match_b_irq = ev_match_b;

        // Toggle flip-flop events first; a command write below overrides them
        next_s.output_toggle_ff = toggled;

        // Register writes take effect at the completing edge
        // Compare loads come as one 16-bit access on the low index, or as a
        // staged low byte and a high byte that commits the pair; a lone high
        // byte commits whatever low byte was staged last
        if (wr_act && lane0) begin
            case (avs_address)
                `IDX_RUN: begin
                    // The run bit gates the counter; the prescaler has its own bit
                    next_s.run = wbyte0[`RUN_COUNT_BIT];
                    next_s.prescaler_run = wbyte0[`RUN_PRESC_BIT];
                    next_s.idle2_run_enable = wbyte0[`RUN_IDLE2_BIT];
                    next_s.double_buffer_enable = wbyte0[`RUN_DBUF_BIT];
                end
                `IDX_MOD: begin
                    // The soft-capture bit is a strobe and keeps no state
                    next_s.clock_select = clock_source_type'(wbyte0[`MOD_CLK_LSB +: 2]);
                    next_s.match_clear_enable = wbyte0[`MOD_CLEAR_BIT];
                end
                `IDX_FFCR: begin
                    next_s.match_a_toggle_enable = wbyte0[`FFCR_TA_BIT];
                    next_s.match_b_toggle_enable = wbyte0[`FFCR_TB_BIT];
                    next_s.capture_toggle_enable = wbyte0[`FFCR_TC_BIT];
                    // A command write wins over any toggle event of the same cycle
                    case (ff_command_type'(wbyte0[`FFCR_CMD_LSB +: 2]))
                        FF_INVERT: next_s.output_toggle_ff = ~s.output_toggle_ff;
                        FF_SET: next_s.output_toggle_ff = 1'b1;
                        FF_CLEAR: next_s.output_toggle_ff = 1'b0;
                        default: next_s.output_toggle_ff = toggled;
                    endcase
                end
                `IDX_CMPA_LO: begin
                    if (lane1) begin
                        // Whole 16-bit load in one access
                        next_s.compare_buffer_a = {wbyte1, wbyte0};
                        if (!s.double_buffer_enable) begin
                            next_s.compare_register_a = {wbyte1, wbyte0};
                        end
                    end else begin
                        next_s.stage_a = wbyte0;
                    end
                end
                `IDX_CMPA_HI: begin
                    // High byte completes the pair staged by the low byte
                    next_s.compare_buffer_a = {wbyte0, s.stage_a};
                    if (!s.double_buffer_enable) begin
                        next_s.compare_register_a = {wbyte0, s.stage_a};
                    end
                end
                `IDX_CMPB_LO: begin
                    if (lane1) begin
                        next_s.compare_register_b = {wbyte1, wbyte0};
                    end else begin
                        next_s.stage_b = wbyte0;
                    end
                end
                `IDX_CMPB_HI: begin
                    // High byte completes the pair staged by the low byte
                    next_s.compare_register_b = {wbyte0, s.stage_b};
                end
                default: begin
                    // Capture registers and unmapped slots ignore writes
                    next_s.stage_a = s.stage_a;
                end
            endcase
        end
    end

    // Single state register; reset gives every field a known value
    // Compare registers and the toggle output are zeroed as well, so a run
    // that skips their loading still starts from known values
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.waitrequest <= 1'b1;
            s.clock_select <= SRC_EXTERNAL;
            s.double_buffer_enable <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    // No output port carries combinational logic
    assign avs_readdata = s.readdata;
    assign avs_waitrequest = s.waitrequest;
    assign timer_output_pin = s.output_toggle_ff;
    assign overflow_irq = s.overflow_irq;
    assign match_a_irq = s.match_a_irq;
    assign match_b_irq = s.match_b_irq;

endmodule

//--- hdl/timer16_params.svh
// Offsets, field positions, reset values and timing counts of the 16-bit timer
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH

// Register indexes; byte address is four times the index
`define IDX_RUN 9'h180
`define IDX_MOD 9'h182
`define IDX_FFCR 9'h183
`define IDX_CMPA_LO 9'h188
`define IDX_CMPA_HI 9'h189
`define IDX_CMPB_LO 9'h18A
`define IDX_CMPB_HI 9'h18B
`define IDX_CAPA_LO 9'h18C
`define IDX_CAPA_HI 9'h18D
`define IDX_CAPB_LO 9'h18E
`define IDX_CAPB_HI 9'h18F

// Run register fields
`define RUN_COUNT_BIT 0
`define RUN_PRESC_BIT 2
`define RUN_IDLE2_BIT 6
`define RUN_DBUF_BIT 7
// Mode register fields
`define MOD_CLK_LSB 0
`define MOD_CLEAR_BIT 2
`define MOD_SOFTCAP_BIT 5
// Toggle control fields
`define FFCR_CMD_LSB 0
`define FFCR_TA_BIT 2
`define FFCR_TB_BIT 3
`define FFCR_TC_BIT 4

// Reset values
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define RESET_READ 32'h0000_0000

// Timing counts
`define PRESC_IN_DIV 4
`define PRESC_WIDTH 5
`define COUNT_MAX 16'hFFFF

`endif

//--- hdl/timer16_pkg.sv
// Types shared by the 16-bit timer design
`include "timer16_params.svh"
package timer16_pkg;

    typedef enum logic [1:0] {
        SRC_EXTERNAL = 2'b00,
        SRC_FINE = 2'b01,
        SRC_MID = 2'b10,
        SRC_COARSE = 2'b11
    } clock_source_type;

    typedef enum logic [1:0] {
        FF_INVERT = 2'b00,
        FF_SET = 2'b01,
        FF_CLEAR = 2'b10,
        FF_KEEP = 2'b11
    } ff_command_type;

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
        logic run;
        logic prescaler_run;
        logic idle2_run_enable;
        logic double_buffer_enable;
        clock_source_type clock_select;
        logic match_clear_enable;
        logic match_a_toggle_enable;
        logic match_b_toggle_enable;
        logic capture_toggle_enable;
        logic [15:0] compare_register_a;
        logic [15:0] compare_buffer_a;
        logic [15:0] compare_register_b;
        logic [7:0] stage_a;
        logic [7:0] stage_b;
        logic [15:0] capture_register_a;
        logic [7:0] read_hold;
        logic [1:0] div4;
        logic [`PRESC_WIDTH-1:0] prescaler;
        logic [15:0] up_counter;
        logic ext_sync1;
        logic ext_sync2;
        logic ext_prev;
        logic output_toggle_ff;
        logic overflow_irq;
        logic match_a_irq;
        logic match_b_irq;
    } timer_state_type;

endpackage

//--- tb/timer16_monitor.sv
// Port-level checker of the timer's bus handshake, pulses and reset state
`timescale 1ns/1ps
`include "timer16_params.svh"
module timer16_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic external_count_input,
    input wire logic idle2_mode,
    input wire logic timer_output_pin,
    input wire logic overflow_irq,
    input wire logic match_a_irq,
    input wire logic match_b_irq
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("bus request not answered in one cycle");
    property p_one_low; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one_low: assert property (p_one_low) else $error("waitrequest low for more than a cycle");
    property p_low_req; !avs_waitrequest |-> (avs_read || avs_write); endproperty
    a_low_req: assert property (p_low_req) else $error("waitrequest low without a request");
    // Read data may only move at the edge that accepts a read
    property p_rd_stable; !$stable(avs_readdata) |-> $past(avs_read) && !avs_waitrequest; endproperty
    a_rd_stable: assert property (p_rd_stable) else $error("read data moved without a read");
    property p_wo_zero;
        avs_read && avs_waitrequest && avs_address inside {`IDX_CMPA_LO, `IDX_CMPA_HI,
            `IDX_CMPB_LO, `IDX_CMPB_HI, `IDX_CAPB_LO, `IDX_CAPB_HI} |=> avs_readdata == 32'h0000_0000;
    endproperty
    a_wo_zero: assert property (p_wo_zero) else $error("write-only place read nonzero");
    property p_run_bits;
        avs_read && avs_waitrequest && avs_address == `IDX_RUN
            |=> avs_readdata[31:8] == 24'h000000 && avs_readdata[5:3] == 3'h0 && !avs_readdata[1];
    endproperty
    a_run_bits: assert property (p_run_bits) else $error("run register spare bits nonzero");
    // A wrap is 65536 ticks apart, so the pulse must stand alone for long
    property p_ovf_pulse; overflow_irq |=> !overflow_irq [*8]; endproperty
    a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse too long");
    property p_match_pulse; match_a_irq || match_b_irq |=> !(match_a_irq || match_b_irq); endproperty
    a_match_pulse: assert property (p_match_pulse) else $error("match pulse too long");
    property p_reset_out;
        $past(rst) |-> avs_waitrequest && avs_readdata == 32'h0000_0000 && !timer_output_pin
            && !overflow_irq && !match_a_irq && !match_b_irq;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
endmodule

bind timer16_capture_ppg timer16_monitor timer16_monitor_i (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .external_count_input(external_count_input),
    .idle2_mode(idle2_mode), .timer_output_pin(timer_output_pin), .overflow_irq(overflow_irq),
    .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));

//--- tb/timer16_capture_ppg_tb.sv
// Self-checking bench of the 16-bit timer with compare, capture and toggle output
`timescale 1ns/1ps
`include "timer16_params.svh"
module timer16_capture_ppg_tb
    import timer16_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] avs_address = 9'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic external_count_input = 1'b0;
    logic idle2_mode = 1'b0;
    logic timer_output_pin, overflow_irq, match_a_irq, match_b_irq;
    int miscompares = 0;
    int samples_checked = 0;
    int ovf_seen = 0;
    int b_seen = 0;
    int n;
    integer seed = 32'h8A7D45BB;
    logic [31:0] q;
    logic [7:0] r;
    logic exp_pin;
    ff_command_type cmd;
    // Reset image of run, mode, toggle control, compare A low and capture B low, plus an unmapped index
    logic [8:0] ra [6] = '{`IDX_RUN, `IDX_MOD, `IDX_FFCR, `IDX_CMPA_LO, `IDX_CAPB_LO, 9'h000};
    logic [31:0] rv [6] = '{32'h0, 32'h20, 32'h03, 32'h0, 32'h0, 32'h0};

    always #5 clk = ~clk;

    // Pulse tallies for the counting model
    always @(posedge clk) begin
        if (overflow_irq === 1'b1) ovf_seen++;
        if (match_b_irq === 1'b1) b_seen++;
    end

    timer16_capture_ppg timer16_capture_ppg_i (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .external_count_input(external_count_input),
        .idle2_mode(idle2_mode), .timer_output_pin(timer_output_pin),
        .overflow_irq(overflow_irq), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));

    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One Avalon transfer; request held until waitrequest is sampled low
    task bus(input logic wr, input logic [8:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        // No local limit: only the watchdog ends a wait that never comes
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Cycles until the chosen match pulse is seen, bounded
    task wait_irq(input int which, output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
        end while (((which == 0) ? match_a_irq : match_b_irq) !== 1'b1 && cyc < 2000);
        if (cyc >= 2000) miscompares++;
    endtask

    initial begin
        // The tests take about a thousand clocks; 20000 clocks means a hang
        #200000;
        miscompares++;
        complete_run;
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Random control values; spare bits must read back clear
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            idle2_mode <= r[3];
            bus(1'b1, `IDX_RUN, {24'h0, r}, 4'h1);
            bus(1'b0, `IDX_RUN, 32'h0, 4'h0);
            chk("run", {24'h0, r & 8'hC5}, q);
            bus(1'b1, `IDX_FFCR, {24'h0, r}, 4'h1);
            bus(1'b0, `IDX_FFCR, 32'h0, 4'h0);
            chk("ffcr", {27'h0, r[4:2], 2'h3}, q);
        end
        idle2_mode <= 1'b0;
        bus(1'b1, `IDX_RUN, 32'h0, 4'h1);
        $display("test registers done");
        // Commands set, clear, invert with all toggle sources off
        exp_pin = 1'b0;
        for (int k = 0; k < 3; k++) begin
            cmd = (k == 0) ? FF_SET : (k == 1) ? FF_CLEAR : FF_INVERT;
            exp_pin = (k == 2) ? !exp_pin : (k == 0);
            bus(1'b1, `IDX_FFCR, {30'h0, cmd}, 4'h1);
            repeat (2) @(posedge clk);
            chk("pin", {31'h0, exp_pin}, {31'h0, timer_output_pin});
        end
        $display("test commands done");
        // PPG with buffered duty: A=2 direct, then 5 into the buffer, B=7 by bytes
        bus(1'b1, `IDX_CMPA_LO, 32'h0002, 4'h3);
        bus(1'b1, `IDX_CMPB_LO, 32'h07, 4'h1);
        bus(1'b1, `IDX_CMPB_HI, 32'h00, 4'h1);
        bus(1'b1, `IDX_RUN, 32'h80, 4'h1);
        bus(1'b1, `IDX_CMPA_LO, 32'h05, 4'h1);
        bus(1'b1, `IDX_CMPA_HI, 32'h00, 4'h1);
        bus(1'b1, `IDX_FFCR, 32'h0E, 4'h1);
        bus(1'b1, `IDX_MOD, {24'h00, 6'h09, SRC_FINE}, 4'h1);
        bus(1'b1, `IDX_RUN, 32'h85, 4'h1);
        wait_irq(1, n);
        repeat (2) @(posedge clk);
        // Cleared, then inverted at A and again at B: low after the first period
        exp_pin = 1'b0;
        chk("pin", {31'h0, exp_pin}, {31'h0, timer_output_pin});
        // Gap b->a spans the clear tick and A ticks; a->b spans B-A; fine tap is 8 clocks
        for (int k = 0; k < 4; k++) begin
            wait_irq(k % 2 == 0 ? 0 : 1, n);
            repeat (2) @(posedge clk);
            chk("gap", (k % 2 == 0) ? (5 + 1) * 8 : (7 - 5) * 8, n + 2);
            exp_pin = !exp_pin;
            chk("pin", {31'h0, exp_pin}, {31'h0, timer_output_pin});
        end
        $display("test ppg done");
        // Soft capture while the counter sits at A, capture toggle only
        bus(1'b1, `IDX_FFCR, 32'h13, 4'h1);
        wait_irq(0, n);
        bus(1'b1, `IDX_MOD, 32'h05, 4'h1);
        exp_pin = !exp_pin;
        bus(1'b0, `IDX_CAPA_LO, 32'h0, 4'h0);
        chk("cap_lo", 32'h0005, q);
        bus(1'b0, `IDX_CAPA_HI, 32'h0, 4'h0);
        chk("cap_hi", 32'h0000, q);
        chk("pin", {31'h0, exp_pin}, {31'h0, timer_output_pin});
        $display("test capture done");
        // External edges with clear at B=3: one match per four edges
        bus(1'b1, `IDX_RUN, 32'h0, 4'h1);
        bus(1'b1, `IDX_MOD, {24'h00, 6'h09, SRC_EXTERNAL}, 4'h1);
        bus(1'b1, `IDX_CMPB_LO, 32'h0003, 4'h3);
        bus(1'b1, `IDX_RUN, 32'h05, 4'h1);
        b_seen = 0;
        for (int k = 0; k < 8; k++) begin
            repeat (4) @(posedge clk);
            external_count_input <= 1'b1;
            repeat (4) @(posedge clk);
            external_count_input <= 1'b0;
        end
        repeat (8) @(posedge clk);
        chk("ext", 8 / (3 + 1), b_seen);
        chk("ovf", 0, ovf_seen);
        $display("test external done");
        // Mid and coarse taps with clear at B=1: B pulses are two ticks apart
        bus(1'b1, `IDX_CMPB_LO, 32'h0001, 4'h3);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, `IDX_MOD, {24'h00, 6'h09, 2'h2 + 2'(k)}, 4'h1);
            wait_irq(1, n);
            wait_irq(1, n);
            chk("tap", (k == 0) ? 2 * 8 * `PRESC_IN_DIV : 2 * 32 * `PRESC_IN_DIV, n);
        end
        $display("test taps done");
        // Reset in mid-run, then the reset image
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            bus(1'b0, ra[k], 32'h0, 4'h0);
            chk("reset", rv[k], q);
        end
        $display("test reset done");
        complete_run;
    end
endmodule
